// ---- dv/fci_flash_model.sv ----
// fci_flash_model: behavioural byte-wide flash with a command latch
// assumes pins come straight from the host; bytes 0..3 start at 00, byte 5 at 3C
`timescale 1ns/1ps
module fci_flash_model #(
  parameter logic [7:0] MAKER_ID = 8'h5E, // arbitrary maker code
  parameter logic [7:0] PART_ID = 8'h6D, // arbitrary device code
  parameter logic [14:0] WEAK_ADDR = 15'h0002 // byte that survives the first erase
) (
  input wire fci_pkg::fci_pins_t pins, // host pin drive
  input wire logic program_supply_high, // supply present
  output logic [7:0] data_lines // data lines seen by host
);
  // ****************************************
  // array and command latch
  // ****************************************
  logic [7:0] mem [0:32767];
  logic [7:0] cmd = fci_pkg::CMD_READ; // not mapped in the array, read at power-up
  logic [7:0] out;
  logic [7:0] last = 8'h00;
  logic [14:0] la = 15'h0000;
  logic [14:0] check_addr = 15'h0000;
  logic [14:0] prog_addr = 15'h0000;
  logic erasing = 1'h0;
  int erase_num = 0;

  // preload the array
  initial
  begin
    for (int i = 0; i < 32768; i++)
      mem[i] = (i < 4) ? 8'h00 : 8'hFF;
    mem[5] = 8'h3C;
  end

  // any supply change leaves the latch at read
  always @(program_supply_high)
    cmd = fci_pkg::CMD_READ;

  // address taken as the strobe falls
  always @(negedge pins.we_b)
  begin
    if (!pins.ce_b)
      la = pins.addr;
  end

  // data taken and acted on as the strobe rises
  always @(posedge pins.we_b)
  begin
    if (!pins.ce_b && !program_supply_high)
      cmd = fci_pkg::CMD_READ;
    else if (!pins.ce_b)
    begin
      if (erasing)
      begin
        for (int i = 0; i < 32768; i++)
          if (i != WEAK_ADDR || erase_num > 1) mem[i] = 8'hFF;
        erasing = 1'h0;
      end
      if (cmd == fci_pkg::CMD_PROG_SETUP)
      begin
        mem[la] = mem[la] & pins.dout;
        prog_addr = la;
        cmd = 8'h01;
      end
      else if (cmd == fci_pkg::CMD_ERASE && pins.dout == fci_pkg::CMD_ERASE)
      begin
        erasing = 1'h1;
        erase_num++;
        cmd = 8'h02;
      end
      else
      begin
        cmd = (cmd == fci_pkg::CMD_RESET && pins.dout == cmd) ? 8'h03 : pins.dout;
        check_addr = la;
      end
    end
  end

  // read data by mode
  always @*
  begin
    case (cmd)
      fci_pkg::CMD_IDENT: out = (pins.addr == 15'h0000) ? MAKER_ID :
        (pins.addr == 15'h0001) ? PART_ID : 8'h00;
      fci_pkg::CMD_ERASE_CHECK: out = mem[check_addr];
      fci_pkg::CMD_PROG_CHECK: out = mem[prog_addr];
      default: out = mem[pins.addr];
    endcase
    if (!pins.ce_b && !pins.oe_b)
      last = out;
  end

  // released lines show the inverse of the last value
  assign data_lines = (!pins.ce_b && !pins.oe_b) ? out : ~last;
endmodule : fci_flash_model

// ---- dv/fci_host_chk.sv ----
// fci_host_chk: pin and handshake properties of the flash host controller
// assumes it is bound into fci_host and sees only that module's ports
`timescale 1ns/1ps
module fci_host_chk #(
  parameter int ERASE_CYCLES = 50, // erase wait in clocks
  parameter int PROG_CYCLES = 5 // program wait in clocks
) (
  input wire logic clk_sys, // system clock
  input wire logic rst_b, // async reset, active low
  input wire logic req_valid, // request present
  input wire logic req_ready, // request taken
  input wire fci_pkg::fci_req_t req, // request fields
  input wire logic rsp_valid, // result pulse
  input wire fci_pkg::fci_rsp_t rsp, // result fields
  input wire logic program_supply_high, // supply present
  input wire logic [7:0] data_lines_in, // flash data lines
  input wire fci_pkg::fci_pins_t pins // flash pin drive
);
  // ****************************************
  // properties on the strobe bus and the request/result handshake
  // ****************************************
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_b);

  a_select_on_write: assert property (!pins.we_b |-> !pins.ce_b)
    else $error("write strobe without select");
  a_no_mixed_strobe: assert property (!(!pins.oe_b && !pins.we_b))
    else $error("read and write strobes low together");
  a_strobe_width: assert property ($fell(pins.we_b) |-> !pins.we_b [*4] ##1 pins.we_b)
    else $error("write strobe not four clocks low");
  a_write_held: assert property (!pins.we_b && !$past(pins.we_b)
    |-> $stable(pins.addr) && $stable(pins.dout))
    else $error("address or data moved inside a write");
  a_drive_on_write: assert property (!pins.we_b |-> pins.doe)
    else $error("write without data drive");
  a_float_on_read: assert property (!pins.oe_b |-> !pins.doe)
    else $error("host drives data during a read");
  a_refuse_no_supply: assert property (req_valid && req_ready && !program_supply_high
    && req.op inside {fci_pkg::FCI_OP_ERASE, fci_pkg::FCI_OP_PROG}
    |-> pins.ce_b throughout (##[1:4] (rsp_valid && !rsp.ok)))
    else $error("alter request without supply not refused");
  a_busy_after_take: assert property (req_valid && req_ready |=> !req_ready)
    else $error("ready stays high after a take");
  a_rsp_one_pulse: assert property (rsp_valid |=> !rsp_valid)
    else $error("result pulse longer than one clock");

  c_result_ok: cover property (rsp_valid && rsp.ok);
  c_result_bad: cover property (rsp_valid && !rsp.ok);
  c_erase_check: cover property ($rose(pins.we_b) && pins.dout == fci_pkg::CMD_ERASE_CHECK);
endmodule : fci_host_chk

bind fci_host fci_host_chk #(.ERASE_CYCLES(ERASE_CYCLES), .PROG_CYCLES(PROG_CYCLES)) chk_u (
  .clk_sys(clk_sys), .rst_b(rst_b), .req_valid(req_valid), .req_ready(req_ready), .req(req),
  .rsp_valid(rsp_valid), .rsp(rsp), .program_supply_high(program_supply_high),
  .data_lines_in(data_lines_in), .pins(pins));

// ---- dv/flash_command_interface_bench.sv ----
// flash_command_interface_bench: directed scenarios for the flash host controller
// assumes fci_flash_model on the far side and short erase and program waits
`timescale 1ns/1ps
module flash_command_interface_bench;
  // ****************************************
  // signals, instances and checks
  // ****************************************
  localparam logic [7:0] MAKER_ID = 8'h5E; // arbitrary maker code
  localparam logic [7:0] PART_ID = 8'h6D; // arbitrary device code
  logic clk_sys = 1'h0;
  logic rst_b = 1'h0;
  logic req_valid = 1'h0;
  logic req_ready;
  fci_pkg::fci_req_t req = '0;
  logic rsp_valid;
  fci_pkg::fci_rsp_t rsp;
  fci_pkg::fci_rsp_t got;
  logic supply = 1'h0;
  logic [7:0] flash_lines;
  logic [7:0] data_in;
  fci_pkg::fci_pins_t pins;
  int bad_count = 0;
  int checks = 0;
  int cyc = 0;
  logic [22:0] wq [$];

  // clock
  always #12.5 clk_sys = ~clk_sys;

  fci_host #(.ERASE_CYCLES(50), .PROG_CYCLES(5)) dut_u (.clk_sys(clk_sys), .rst_b(rst_b),
    .req_valid(req_valid), .req_ready(req_ready), .req(req), .rsp_valid(rsp_valid), .rsp(rsp),
    .program_supply_high(supply), .data_lines_in(data_in), .pins(pins));
  fci_flash_model #(.MAKER_ID(MAKER_ID), .PART_ID(PART_ID)) flash_u (.pins(pins),
    .program_supply_high(supply), .data_lines(flash_lines));
  assign data_in = pins.doe ? pins.dout : flash_lines;

  // log every completed write
  always @(posedge pins.we_b)
  begin
    if (!pins.ce_b)
      wq.push_back({pins.dout, pins.addr});
  end

  // hang guard
  always @(posedge clk_sys)
  begin
    cyc <= cyc + 1;
    if (cyc == 30000)
    begin
      bad_count++;
      close_out();
    end
  end

  task automatic close_out;
    $display("checks %0d bad_count %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : close_out

  task automatic tally(input logic hit, input string what);
    checks++;
    if (hit !== 1'h1)
    begin
      bad_count++;
      $display("BAD t=%0t %s", $time, what);
    end
  endtask : tally

  task automatic chk_byte(input logic [7:0] g, input logic [7:0] e, input string what);
    tally(g === e, what);
  endtask : chk_byte

  task automatic chk_addr(input logic [14:0] g, input logic [14:0] e, input string what);
    tally(g === e, what);
  endtask : chk_addr

  task automatic send_req(input fci_pkg::fci_op_t op, input logic [14:0] a,
                          input logic [7:0] d, input logic sup);
    req_valid <= 1'h1;
    req <= '{op: op, addr: a, data: d};
    supply <= sup;
    @(negedge clk_sys);
    while (!req_ready)
      @(negedge clk_sys);
    @(posedge clk_sys);
    req_valid <= 1'h0;
  endtask : send_req

  task automatic do_op(input fci_pkg::fci_op_t op, input logic [14:0] a,
                       input logic [7:0] d, input logic sup);
    int n;
    send_req(op, a, d, sup);
    n = 0;
    @(negedge clk_sys);
    while (rsp_valid !== 1'h1 && n < 3000)
    begin
      @(negedge clk_sys);
      n++;
    end
    got = rsp;
    tally(n < 3000, "no answer");
    @(posedge clk_sys);
  endtask : do_op

  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_quiet(input string what);
    @(negedge clk_sys);
    chk_byte({pins.ce_b, pins.oe_b, pins.we_b, pins.doe, req_ready, rsp_valid, 2'h0}, 8'hE8,
      what);
    @(posedge clk_sys);
    $display("done quiet %s", what);
  endtask : t_quiet

  task automatic t_ident;
    do_op(fci_pkg::FCI_OP_IDENT, 15'h0000, 8'h00, 1'h1);
    chk_byte(got.data, MAKER_ID, "maker code");
    do_op(fci_pkg::FCI_OP_IDENT, 15'h0001, 8'h00, 1'h1);
    chk_byte(got.data, PART_ID, "device code");
    do_op(fci_pkg::FCI_OP_READ, 15'h0005, 8'h00, 1'h1);
    chk_byte(got.data, 8'h3C, "array after ident");
    do_op(fci_pkg::FCI_OP_READ, 15'h0005, 8'h00, 1'h0);
    chk_byte(got.data, 8'h3C, "array with supply low");
    $display("done ident and read");
  endtask : t_ident

  task automatic t_program;
    do_op(fci_pkg::FCI_OP_PROG, 15'h0010, 8'h5A, 1'h1);
    tally(got.ok === 1'h1, "program pass flag");
    chk_addr(got.addr, 15'h0010, "program address");
    do_op(fci_pkg::FCI_OP_READ, 15'h0010, 8'h00, 1'h1);
    chk_byte(got.data, 8'h5A, "programmed byte");
    do_op(fci_pkg::FCI_OP_PROG, 15'h0010, 8'hA5, 1'h1);
    tally(got.ok === 1'h0, "mismatch flagged");
    chk_byte(got.data, 8'h00, "margin read value");
    $display("done program");
  endtask : t_program

  task automatic t_refuse;
    do_op(fci_pkg::FCI_OP_PROG, 15'h0020, 8'h11, 1'h0);
    tally(got.ok === 1'h0, "program refused");
    do_op(fci_pkg::FCI_OP_ERASE, 15'h0000, 8'h00, 1'h0);
    tally(got.ok === 1'h0, "erase refused");
    do_op(fci_pkg::FCI_OP_READ, 15'h0020, 8'h00, 1'h0);
    chk_byte(got.data, 8'hFF, "byte kept");
    do_op(fci_pkg::FCI_OP_READ, 15'h0000, 8'h00, 1'h0);
    chk_byte(got.data, 8'h00, "array kept");
    $display("done refuse");
  endtask : t_refuse

  task automatic t_erase;
    logic [7:0] exp_d [9] = '{8'h20, 8'h20, 8'hA0, 8'hA0, 8'hA0, 8'h20, 8'h20, 8'hA0, 8'hA0};
    logic [14:0] exp_a [9] = '{15'h0, 15'h0, 15'h0, 15'h1, 15'h2, 15'h0, 15'h0, 15'h2, 15'h3};
    int n;
    wq.delete();
    send_req(fci_pkg::FCI_OP_ERASE, 15'h0000, 8'h00, 1'h1);
    n = 0;
    while (wq.size() < 9 && n < 3000)
    begin
      @(negedge clk_sys);
      n++;
    end
    tally(wq.size() >= 9, "erase writes missing");
    for (int i = 0; i < 9 && i < wq.size(); i++)
    begin
      chk_byte(wq[i][22:15], exp_d[i], "erase write code");
      if (exp_d[i] == 8'hA0)
        chk_addr(wq[i][14:0], exp_a[i], "check address");
    end
    @(posedge clk_sys);
    rst_b <= 1'h0;
    repeat (3) @(posedge clk_sys);
    t_quiet("in reset");
    rst_b <= 1'h1;
    t_quiet("after second reset");
    do_op(fci_pkg::FCI_OP_READ, 15'h0000, 8'h00, 1'h0);
    chk_byte(got.data, 8'hFF, "erased byte");
    $display("done erase");
  endtask : t_erase

  // main sequence
  initial
  begin
    repeat (10) @(posedge clk_sys);
    rst_b <= 1'h1;
    t_quiet("after reset");
    t_ident();
    t_program();
    t_refuse();
    t_erase();
    close_out();
  end
endmodule : flash_command_interface_bench

// ---- hw/fci_bus_cycle.sv ----
// fci_bus_cycle: one timed strobe cycle (write or read) on the flash pins
// assumes the flash needs no clock; strobe widths come from fci_pkg counts
`timescale 1ns/1ps
module fci_bus_cycle (
  input wire logic clk_sys, // system clock
  input wire logic rst_b, // async reset, active low
  input wire logic start, // pulse: begin one cycle
  input wire logic is_write, // 1 write, 0 read
  input wire logic [14:0] addr, // byte address
  input wire logic [7:0] wdata, // write data
  input wire logic [7:0] din, // data lines from flash
  output fci_pkg::fci_pins_t pins, // flash pin drive
  output logic done, // pulse: cycle finished
  output logic [7:0] rdata // sampled read data
);
  typedef enum logic [1:0] {BC_IDLE, BC_LOW, BC_GAP} fci_bc_t;
  fci_bc_t state;
  logic [3:0] cnt;
  logic wr;

  // ***************************************************************
  // strobe sequencing
  // ***************************************************************
  // select and strobe together low form the command write
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      state <= BC_IDLE;
      cnt <= 4'h0;
      wr <= 1'b0;
      pins <= '{ce_b: 1'b1, oe_b: 1'b1, we_b: 1'b1, addr: 15'h0000, dout: 8'h00, doe: 1'b0};
    end
    else
    begin
      unique case (state)
        BC_IDLE:
        begin
          if (start)
          begin
            wr <= is_write;
            pins.addr <= addr; // driven on the same edge the strobe falls [R2]
            pins.dout <= wdata; // held past strobe rise [R2]
            pins.doe <= is_write; // host floats lines on reads [R20]
            pins.ce_b <= 1'b0;
            pins.we_b <= ~is_write; // [R1]
            pins.oe_b <= is_write; // gate high during writes [R21]
            cnt <= 4'(fci_pkg::STROBE_CYC);
            state <= BC_LOW;
          end
        end
        BC_LOW:
        begin
          if (cnt == 4'h1)
          begin
            pins.we_b <= 1'b1;
            pins.oe_b <= 1'b1;
            cnt <= 4'(fci_pkg::SETUP_CYC);
            state <= BC_GAP;
          end
          else
          begin
            cnt <= cnt - 4'h1;
          end
        end
        BC_GAP:
        begin
          pins.ce_b <= 1'b1; // standby between cycles [R22]
          pins.doe <= 1'b0;
          if (cnt == 4'h1)
          begin
            state <= BC_IDLE;
          end
          else
          begin
            cnt <= cnt - 4'h1;
          end
        end
      endcase
    end
  end

  // read data sampled at the last low cycle with gate low
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
      rdata <= 8'h00;
    else if (state == BC_LOW && cnt == 4'h1 && !wr)
      rdata <= din; // [R20]
  end

  assign done = (state == BC_GAP) && (cnt == 4'h1);
endmodule : fci_bus_cycle

// ---- hw/fci_host.sv ----
// fci_host: controller that runs read, identifier, erase and program sequences
// assumes the flash pins are wired straight to the memory; supply switching external
`timescale 1ns/1ps
module fci_host #(
  parameter int ERASE_CYCLES = fci_pkg::ERASE_CYC, // erase pulse length in clocks
  parameter int PROG_CYCLES = fci_pkg::PROG_CYC // program pulse length in clocks
) (
  input wire logic clk_sys, // system clock 40 MHz
  input wire logic rst_b, // async reset, active low
  input wire logic req_valid, // request present
  output logic req_ready, // request taken when both high
  input wire fci_pkg::fci_req_t req, // operation, address, data
  output logic rsp_valid, // pulse: result ready
  output fci_pkg::fci_rsp_t rsp, // result data, pass flag, address
  input wire logic program_supply_high, // programming supply present
  input wire logic [7:0] data_lines_in, // data lines from flash
  output fci_pkg::fci_pins_t pins // flash pin drive
);
  typedef enum logic [3:0] {
    S_IDLE, S_CMD, S_CMD2, S_PULSE, S_VERIFY, S_VREAD, S_RESET1, S_RESET2, S_EXIT, S_DONE
  } fci_st_t;

  fci_st_t state;
  fci_pkg::fci_req_t cur;
  logic [14:0] addr; // erase verify pointer, kept across re-erases
  logic [19:0] wait_cnt;
  logic bc_start;
  logic bc_write;
  logic [14:0] bc_addr;
  logic [7:0] bc_wdata;
  logic bc_done;
  logic [7:0] bc_rdata;
  logic issued;
  logic ok;
  logic [7:0] result;

  // ***************************************************************
  // bus cycle engine
  // ***************************************************************
  fci_bus_cycle u_cycle (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .start(bc_start),
    .is_write(bc_write),
    .addr(bc_addr),
    .wdata(bc_wdata),
    .din(data_lines_in),
    .pins(pins),
    .done(bc_done),
    .rdata(bc_rdata)
  );

  assign req_ready = (state == S_IDLE);
  assign bc_start = !issued && state != S_IDLE && state != S_PULSE && state != S_DONE;

  // ***************************************************************
  // cycle selection per state
  // ***************************************************************
  // picks the command byte or read address for the current step
  always_comb
  begin
    bc_write = 1'b1;
    bc_addr = 15'h0000;
    bc_wdata = fci_pkg::CMD_READ;
    unique case (state)
      S_CMD:
      begin
        unique case (cur.op)
          fci_pkg::FCI_OP_READ: bc_wdata = fci_pkg::CMD_READ; // [R6]
          fci_pkg::FCI_OP_IDENT: bc_wdata = fci_pkg::CMD_IDENT; // [R8]
          fci_pkg::FCI_OP_ERASE: bc_wdata = fci_pkg::CMD_ERASE; // arm only [R10]
          default: bc_wdata = fci_pkg::CMD_PROG_SETUP; // [R18]
        endcase
      end
      S_CMD2:
      begin
        unique case (cur.op)
          fci_pkg::FCI_OP_ERASE: bc_wdata = fci_pkg::CMD_ERASE; // starts erase [R10]
          fci_pkg::FCI_OP_PROG:
          begin
            bc_addr = cur.addr; // target_byte_address [R18]
            bc_wdata = cur.data; // target_byte_value
          end
          default:
          begin
            bc_write = 1'b0; // array or identifier read [R8]
            bc_addr = cur.addr;
          end
        endcase
      end
      S_VERIFY:
      begin
        if (cur.op == fci_pkg::FCI_OP_ERASE)
        begin
          bc_addr = addr; // erase_check_address, fresh each byte [R13] [R15]
          bc_wdata = fci_pkg::CMD_ERASE_CHECK; // ends erase pulse [R11]
        end
        else
        begin
          bc_wdata = fci_pkg::CMD_PROG_CHECK; // ends program pulse [R18]
        end
      end
      S_VREAD:
      begin
        bc_write = 1'b0;
        bc_addr = (cur.op == fci_pkg::FCI_OP_ERASE) ? addr : cur.addr;
      end
      S_RESET1, S_RESET2: bc_wdata = fci_pkg::CMD_RESET; // [R19]
      S_EXIT: bc_wdata = fci_pkg::CMD_READ; // leaves verify mode [R17] [R19]
      default: bc_wdata = fci_pkg::CMD_READ;
    endcase
  end

  // ***************************************************************
  // sequencer
  // ***************************************************************
  // issued marks that the current step's bus cycle has begun
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
      issued <= 1'b0;
    else if (bc_done)
      issued <= 1'b0;
    else if (bc_start)
      issued <= 1'b1;
  end

  // main operation flow
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      state <= S_IDLE;
      cur <= '{op: fci_pkg::FCI_OP_READ, addr: 15'h0000, data: 8'h00};
      addr <= 15'h0000;
      wait_cnt <= 20'h00000;
      ok <= 1'b0;
      result <= 8'h00;
    end
    else
    begin
      unique case (state)
        S_IDLE:
        begin
          if (req_valid)
          begin
            cur <= req;
            addr <= 15'h0000;
            ok <= 1'b0;
            // erase and program need the supply; else read-only [R5] [R24]
            if ((req.op == fci_pkg::FCI_OP_ERASE || req.op == fci_pkg::FCI_OP_PROG)
                && !program_supply_high)
              state <= S_DONE;
            else if (!program_supply_high && req.op == fci_pkg::FCI_OP_READ)
              state <= S_CMD2; // latch already forced to read [R4] [R7]
            else
              state <= S_CMD;
          end
        end
        S_CMD:
        begin
          if (bc_done)
            state <= S_CMD2;
        end
        S_CMD2:
        begin
          if (bc_done)
          begin
            if (cur.op == fci_pkg::FCI_OP_READ || cur.op == fci_pkg::FCI_OP_IDENT)
            begin
              result <= bc_rdata; // identifier mode held until next command [R9]
              ok <= 1'b1;
              state <= S_DONE;
            end
            else
            begin
              wait_cnt <= (cur.op == fci_pkg::FCI_OP_ERASE) ? 20'(ERASE_CYCLES)
                                                              : 20'(PROG_CYCLES);
              state <= S_PULSE;
            end
          end
        end
        S_PULSE:
        begin
          // whole array erases at once during this wait [R12]
          if (wait_cnt <= 20'h00001)
            state <= S_VERIFY; // verify also wakes a timed-out device [R23]
          else
            wait_cnt <= wait_cnt - 20'h00001;
        end
        S_VERIFY:
        begin
          if (bc_done)
            state <= S_VREAD;
        end
        S_VREAD:
        begin
          if (bc_done)
          begin
            result <= bc_rdata;
            if (cur.op == fci_pkg::FCI_OP_PROG)
            begin
              ok <= (bc_rdata == cur.data);
              state <= S_EXIT;
            end
            else if (bc_rdata != fci_pkg::ERASED_VALUE)
              state <= S_CMD; // re-erase, keep pointer [R16]
            else if (addr == fci_pkg::LAST_ADDR)
            begin
              ok <= 1'b1; // all ones everywhere [R14]
              state <= S_EXIT;
            end
            else
            begin
              addr <= addr + 15'h0001;
              state <= S_VERIFY; // [R15]
            end
          end
        end
        S_RESET1:
        begin
          if (bc_done)
            state <= S_RESET2;
        end
        S_RESET2:
        begin
          if (bc_done)
            state <= S_EXIT;
        end
        S_EXIT:
        begin
          if (bc_done)
            state <= S_DONE;
        end
        S_DONE: state <= S_IDLE;
      endcase
    end
  end

  // ***************************************************************
  // result output
  // ***************************************************************
  // result registers stand until the next request
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
      rsp <= '{data: 8'h00, ok: 1'b0, addr: 15'h0000};
    else if (state == S_DONE)
      rsp <= '{data: result, ok: ok, addr: (cur.op == fci_pkg::FCI_OP_ERASE) ? addr : cur.addr};
  end

  // command latch address decoding is the device's concern [R3]
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
      rsp_valid <= 1'b0;
    else
      rsp_valid <= (state == S_DONE);
  end
endmodule : fci_host

// ---- include/fci_pkg.sv ----
// fci_pkg: constants and carrier types for the flash command host controller
// assumes a byte-wide flash with an asynchronous strobe bus, driven from clk_sys
// Operation
// R1: write means write strobe low with select low
// R2: device latches address on fall, data rise
// R3: command latch has no memory address
// R4: low programming supply forces read-array code
// R5: erasure only while programming supply high
// R6: read-array code makes reads return array
// R7: latch holds read-array code at supply power-up
// R8: identifier reads: address zero maker, one device
// R9: identifier mode holds until next command
// R10: chip erase needs two erase writes
// R11: erase runs until erase-verify write rises
// R12: erase clears whole array in parallel
// R13: erase-verify write carries checked address
// R14: erase-verify read all ones means erased
// R15: new erase-verify address before each check
// R16: on failure re-erase, resume at last address
// R17: leave verify mode with another command
// R18: program: setup, address/data, verify, read
// R19: reset is two all-ones writes, then command
// R20: device drives data with select and gate low
// R21: gate high floats the data lines
// R22: select high means standby, outputs floated
// R23: stop timer leaves device idle until verify
// R24: writes with supply low change nothing
package fci_pkg;

  // ***************************************************************
  // command codes
  // ***************************************************************
  localparam logic [7:0] CMD_READ = 8'h00;
  localparam logic [7:0] CMD_IDENT = 8'h90;
  localparam logic [7:0] CMD_ERASE = 8'h20;
  localparam logic [7:0] CMD_ERASE_CHECK = 8'hA0;
  localparam logic [7:0] CMD_PROG_SETUP = 8'h40;
  localparam logic [7:0] CMD_PROG_CHECK = 8'hC0;
  localparam logic [7:0] CMD_RESET = 8'hFF;
  localparam logic [7:0] ERASED_VALUE = 8'hFF;

  // ***************************************************************
  // widths and timing
  // ***************************************************************
  localparam int ADDR_W = 15;
  localparam logic [14:0] LAST_ADDR = 15'h7FFF;
  localparam int CLK_PERIOD_NS = 25;
  localparam int STROBE_NS = 100; // least strobe low time
  localparam int SETUP_NS = 50; // least idle between strobes
  localparam int STROBE_CYC = (STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SETUP_CYC = (SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ERASE_US = 10000;
  localparam int PROG_US = 10;
  localparam int ERASE_CYC = ERASE_US * 1000 / CLK_PERIOD_NS;
  localparam int PROG_CYC = PROG_US * 1000 / CLK_PERIOD_NS;
  localparam int WAIT_W = 20;

  // ***************************************************************
  // carrier types
  // ***************************************************************
  typedef enum logic [2:0] {
    FCI_OP_READ,
    FCI_OP_IDENT,
    FCI_OP_ERASE,
    FCI_OP_PROG
  } fci_op_t;

  typedef struct packed {
    fci_op_t op;
    logic [14:0] addr;
    logic [7:0] data;
  } fci_req_t;

  typedef struct packed {
    logic [7:0] data;
    logic ok;
    logic [14:0] addr;
  } fci_rsp_t;

  typedef struct packed {
    logic ce_b;
    logic oe_b;
    logic we_b;
    logic [14:0] addr;
    logic [7:0] dout;
    logic doe;
  } fci_pins_t;

endpackage : fci_pkg
